//--- rtl/pme_pkg.sv
// Purpose: shared constants and types of the power mode entry and wake block
// Assumes: 32-bit Avalon-MM register bus with byte addresses, one word per register
// Notes: all offsets, field positions and reset values live here
package pme_pkg;

	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 32;

	// register byte offsets
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_STAT = 8'h04;
	localparam logic [7:0] OFF_INTERRUPT_CONTROL_REGISTER = 8'h08;
	localparam logic [7:0] OFF_PIE = 8'h0C;
	localparam logic [7:0] OFF_EVT = 8'h10;
	localparam logic [7:0] OFF_MASK = 8'h14;

	// control register fields
	localparam int unsigned CTRL_IDLE_BIT = 0;
	localparam int unsigned CTRL_SCS_LSB = 1;
	localparam int unsigned CTRL_WDT_BIT = 3;
	localparam int unsigned CTRL_T1_BIT = 4;
	localparam int unsigned CTRL_W = 5;

	// status register fields
	localparam int unsigned STAT_POSC_BIT = 0;
	localparam int unsigned STAT_IOSC_BIT = 1;
	localparam int unsigned STAT_T1_BIT = 2;
	localparam int unsigned STAT_MODE_LSB = 3;
	localparam int unsigned STAT_HALT_BIT = 5;

	// interrupt control register fields
	localparam int unsigned INTERRUPT_CONTROL_REGISTER_GIE_BIT = 7;
	localparam int unsigned INTERRUPT_CONTROL_REGISTER_W = 8;

	// sticky event bits
	localparam int unsigned EVT_IDLE = 0;
	localparam int unsigned EVT_SLEEP = 1;
	localparam int unsigned EVT_IRQ_WAKE = 2;
	localparam int unsigned EVT_WDT_WAKE = 3;
	localparam int unsigned EVT_W = 4;

	// values after reset
	localparam logic [4:0] CTRL_RST = 5'h00;
	localparam logic [7:0] INTERRUPT_CONTROL_REGISTER_RST = 8'h00;
	localparam logic [7:0] PIE_RST = 8'h00;
	localparam logic [3:0] EVT_RST = 4'h0;
	localparam logic [3:0] MASK_RST = 4'h0;

	// depth of the pin synchroniser
	localparam int unsigned SYNC_STAGES = 3;

	typedef enum logic [1:0] {
		PME_RUN,
		PME_IDLE,
		PME_SLEEP
	} pme_mode_e;

	typedef struct packed {
		logic cpu_clk_en;
		logic periph_clk_en;
		logic primary_osc_en;
		logic intosc_en;
		logic low_freq_internal_rc_en;
		logic timer1_osc_en;
	} pme_clk_s;

	typedef struct packed {
		logic primary_osc_ready_flag;
		logic internal_osc_stable_flag;
		logic timer1_osc_running_flag;
	} pme_flags_s;

endpackage

//--- rtl/pme_sync3.sv
// Purpose: three-stage synchroniser for levels arriving from outside the mclk domain
// Assumes: each bit is an independent slow level
// Notes: output changes only once the second and third stages agree
`timescale 1ns/1ns
module pme_sync3 #(
	parameter int unsigned W = 1
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);

	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			logic s1_reg;
			logic s2_reg;
			logic s3_reg;
			always_ff @(posedge mclk or negedge rst_n) begin
				if (!rst_n) begin
					s1_reg <= 1'b0;
					s2_reg <= 1'b0;
					s3_reg <= 1'b0;
				end else begin
					s1_reg <= async_in[i];
					s2_reg <= s1_reg;
					s3_reg <= s2_reg;
				end
			end
			always_ff @(posedge mclk or negedge rst_n) begin
				if (!rst_n) begin
					sync_out[i] <= 1'b0;
				end else if (s2_reg == s3_reg) begin
					sync_out[i] <= s3_reg;
				end
			end
		end
	endgenerate

endmodule

//--- rtl/pme_power_mode.sv
// Purpose: low-power mode entry, clock gating and wake control for the core
// Assumes: sleep_exec, wdt_timeout and interrupt flags are on mclk; oscillator status pins are not
// Notes: registers are reached over Avalon-MM; every request answers on its second edge
`timescale 1ns/1ns
module pme_power_mode #(
	parameter int unsigned NUM_CORE_SRC = 4,
	parameter int unsigned NUM_PERIPH_SRC = 8
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [pme_pkg::ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [pme_pkg::DATA_W-1:0] avs_writedata,
	output logic [pme_pkg::DATA_W-1:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic sleep_exec,
	input wire logic [NUM_CORE_SRC-1:0] core_int_flag,
	input wire logic [NUM_PERIPH_SRC-1:0] periph_int_flag,
	input wire logic wdt_timeout,
	input wire logic primary_osc_ready_pin,
	input wire logic intosc_stable_pin,
	input wire logic t1osc_running_pin,
	output logic cpu_halt,
	output pme_pkg::pme_clk_s clk_ctl,
	output logic [1:0] periph_clk_sel,
	output pme_pkg::pme_flags_s osc_flags,
	output logic wake_to_vector,
	output logic wake_in_line,
	output logic irq
);

	logic [pme_pkg::CTRL_W-1:0] ctrl_reg;
	logic [pme_pkg::INTERRUPT_CONTROL_REGISTER_W-1:0] interrupt_control_register;
	logic [NUM_PERIPH_SRC-1:0] peripheral_interrupt_enable_register;
	logic [pme_pkg::EVT_W-1:0] evt_reg;
	logic [pme_pkg::EVT_W-1:0] mask_reg;
	logic [pme_pkg::EVT_W-1:0] evt_set;
	pme_pkg::pme_mode_e mode_reg;
	pme_pkg::pme_mode_e mode_next;
	logic [1:0] sel_held_reg;
	logic [2:0] osc_sync;

	logic idle_on_halt_select;
	logic [1:0] system_clock_select;
	logic watchdog_timer_en;
	logic timer1_osc_enable;
	logic global_interrupt_enable;
	logic low_power;
	logic wake_irq;
	logic wake_wdt;
	logic enter_idle;
	logic enter_sleep;
	logic bus_req;
	logic wr_acc;
	logic rd_acc;

	assign idle_on_halt_select = ctrl_reg[pme_pkg::CTRL_IDLE_BIT];
	assign system_clock_select = ctrl_reg[pme_pkg::CTRL_SCS_LSB +: 2];
	assign watchdog_timer_en = ctrl_reg[pme_pkg::CTRL_WDT_BIT];
	assign timer1_osc_enable = ctrl_reg[pme_pkg::CTRL_T1_BIT];
	assign global_interrupt_enable = interrupt_control_register[pme_pkg::INTERRUPT_CONTROL_REGISTER_GIE_BIT];

	pme_sync3 #(
		.W(3)
	) u_sync (
		.mclk(mclk),
		.rst_n(rst_n),
		.async_in({primary_osc_ready_pin, intosc_stable_pin, t1osc_running_pin}),
		.sync_out(osc_sync)
	);

	// bus: a request is answered with waitrequest low on its second edge
	assign bus_req = avs_read | avs_write;
	assign wr_acc = avs_write & ~avs_waitrequest;
	assign rd_acc = avs_read & avs_waitrequest;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			avs_waitrequest <= 1'b1;
		end else begin
			avs_waitrequest <= ~(bus_req & avs_waitrequest);
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			avs_readdata <= 32'h0000_0000;
		end else if (rd_acc) begin
			avs_readdata <= 32'h0000_0000;
			case (avs_address)
				pme_pkg::OFF_CTRL: begin
					avs_readdata[pme_pkg::CTRL_W-1:0] <= ctrl_reg;
				end
				pme_pkg::OFF_STAT: begin
					avs_readdata[pme_pkg::STAT_POSC_BIT] <= osc_flags.primary_osc_ready_flag;
					avs_readdata[pme_pkg::STAT_IOSC_BIT] <= osc_flags.internal_osc_stable_flag;
					avs_readdata[pme_pkg::STAT_T1_BIT] <= osc_flags.timer1_osc_running_flag;
					avs_readdata[pme_pkg::STAT_MODE_LSB +: 2] <= mode_reg;
					avs_readdata[pme_pkg::STAT_HALT_BIT] <= cpu_halt;
				end
				pme_pkg::OFF_INTERRUPT_CONTROL_REGISTER: begin
					avs_readdata[pme_pkg::INTERRUPT_CONTROL_REGISTER_W-1:0] <= interrupt_control_register;
				end
				pme_pkg::OFF_PIE: begin
					avs_readdata[NUM_PERIPH_SRC-1:0] <= peripheral_interrupt_enable_register;
				end
				pme_pkg::OFF_EVT: begin
					avs_readdata[pme_pkg::EVT_W-1:0] <= evt_reg;
				end
				pme_pkg::OFF_MASK: begin
					avs_readdata[pme_pkg::EVT_W-1:0] <= mask_reg;
				end
				default: begin
					avs_readdata <= 32'h0000_0000;
				end
			endcase
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_reg <= pme_pkg::CTRL_RST;
			interrupt_control_register <= pme_pkg::INTERRUPT_CONTROL_REGISTER_RST;
			peripheral_interrupt_enable_register <= NUM_PERIPH_SRC'(pme_pkg::PIE_RST);
			mask_reg <= pme_pkg::MASK_RST;
		end else if (wr_acc) begin
			case (avs_address)
				pme_pkg::OFF_CTRL: begin
					ctrl_reg <= avs_writedata[pme_pkg::CTRL_W-1:0];
				end
				pme_pkg::OFF_INTERRUPT_CONTROL_REGISTER: begin
					interrupt_control_register <= avs_writedata[pme_pkg::INTERRUPT_CONTROL_REGISTER_W-1:0];
				end
				pme_pkg::OFF_PIE: begin
					peripheral_interrupt_enable_register <= avs_writedata[NUM_PERIPH_SRC-1:0];
				end
				pme_pkg::OFF_MASK: begin
					mask_reg <= avs_writedata[pme_pkg::EVT_W-1:0];
				end
				default: begin
				end
			endcase
		end
	end

	// wake causes; only enabled interrupt sources count, a watchdog time-out wakes even with the watchdog enable clear
	assign low_power = (mode_reg != pme_pkg::PME_RUN);
	assign wake_irq = low_power & (|(core_int_flag &
		interrupt_control_register[NUM_CORE_SRC-1:0]) |
		|(periph_int_flag & peripheral_interrupt_enable_register));
	assign wake_wdt = low_power & wdt_timeout;
	assign enter_idle = (mode_reg == pme_pkg::PME_RUN) & sleep_exec & idle_on_halt_select;
	// clock select nonzero with idle clear also sleeps, as from full power
	assign enter_sleep = (mode_reg == pme_pkg::PME_RUN) & sleep_exec & ~idle_on_halt_select;

	always_comb begin
		mode_next = mode_reg;
		case (mode_reg)
			pme_pkg::PME_RUN: begin
				if (enter_idle) begin
					mode_next = pme_pkg::PME_IDLE;
				end else if (enter_sleep) begin
					mode_next = pme_pkg::PME_SLEEP;
				end
			end
			pme_pkg::PME_IDLE, pme_pkg::PME_SLEEP: begin
				if (wake_irq | wake_wdt) begin
					mode_next = pme_pkg::PME_RUN;
				end
			end
			default: begin
				mode_next = pme_pkg::PME_RUN;
			end
		endcase
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			mode_reg <= pme_pkg::PME_RUN;
		end else begin
			mode_reg <= mode_next;
		end
	end

	// core halts from the edge after the sleep instruction, so the next one does not run
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cpu_halt <= 1'b0;
		end else begin
			cpu_halt <= (mode_next != pme_pkg::PME_RUN);
		end
	end

	// peripheral clock source frozen at entry
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			sel_held_reg <= 2'h0;
		end else if (!low_power) begin
			sel_held_reg <= system_clock_select;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			periph_clk_sel <= 2'h0;
		end else if (mode_next == pme_pkg::PME_RUN) begin
			periph_clk_sel <= system_clock_select;
		end else if (!low_power) begin
			periph_clk_sel <= system_clock_select;
		end else begin
			periph_clk_sel <= sel_held_reg;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			clk_ctl <= '{cpu_clk_en: 1'b1, periph_clk_en: 1'b1, primary_osc_en: 1'b1,
				intosc_en: 1'b1, low_freq_internal_rc_en: 1'b1, timer1_osc_en: 1'b0};
		end else begin
			clk_ctl.cpu_clk_en <= (mode_next == pme_pkg::PME_RUN);
			clk_ctl.periph_clk_en <= (mode_next != pme_pkg::PME_SLEEP);
			clk_ctl.primary_osc_en <= (mode_next != pme_pkg::PME_SLEEP);
			clk_ctl.intosc_en <= (mode_next != pme_pkg::PME_SLEEP);
			clk_ctl.low_freq_internal_rc_en <= (mode_next != pme_pkg::PME_SLEEP) |
				watchdog_timer_en;
			clk_ctl.timer1_osc_en <= timer1_osc_enable;
		end
	end

	// flags track the synchronised pins, frozen in Idle, held clear in Sleep
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			osc_flags <= '{primary_osc_ready_flag: 1'b0, internal_osc_stable_flag: 1'b0,
				timer1_osc_running_flag: 1'b0};
		end else if (mode_next == pme_pkg::PME_SLEEP) begin
			osc_flags <= '{primary_osc_ready_flag: 1'b0, internal_osc_stable_flag: 1'b0,
				timer1_osc_running_flag: 1'b0};
		end else if (mode_next == pme_pkg::PME_IDLE) begin
			osc_flags <= osc_flags;
		end else begin
			osc_flags.primary_osc_ready_flag <= osc_sync[2];
			osc_flags.internal_osc_stable_flag <= osc_sync[1];
			osc_flags.timer1_osc_running_flag <= osc_sync[0];
		end
	end

	// one-cycle resume pulses to the core on interrupt or watchdog wake
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			wake_to_vector <= 1'b0;
			wake_in_line <= 1'b0;
		end else begin
			wake_to_vector <= wake_irq & global_interrupt_enable;
			wake_in_line <= (wake_irq & ~global_interrupt_enable) | (wake_wdt & ~wake_irq);
		end
	end

	// sticky events; a set in the clearing cycle wins
	assign evt_set[pme_pkg::EVT_IDLE] = enter_idle;
	assign evt_set[pme_pkg::EVT_SLEEP] = enter_sleep;
	assign evt_set[pme_pkg::EVT_IRQ_WAKE] = wake_irq;
	assign evt_set[pme_pkg::EVT_WDT_WAKE] = wake_wdt;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			evt_reg <= pme_pkg::EVT_RST;
		end else if (wr_acc && avs_address == pme_pkg::OFF_EVT) begin
			evt_reg <= (evt_reg & ~avs_writedata[pme_pkg::EVT_W-1:0]) | evt_set;
		end else begin
			evt_reg <= evt_reg | evt_set;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			irq <= 1'b0;
		end else begin
			irq <= |(evt_reg & mask_reg);
		end
	end

endmodule

//--- bench/pme_power_mode_chk.sv
// Purpose: port-level checks of the power mode block
// Assumes: one mclk domain, rst_n active low
// Notes: sleep is told from idle by the peripheral clock enable
`timescale 1ns/1ns
module pme_power_mode_chk #(
	parameter int unsigned NUM_CORE_SRC = 4,
	parameter int unsigned NUM_PERIPH_SRC = 8
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic sleep_exec,
	input wire logic [NUM_CORE_SRC-1:0] core_int_flag,
	input wire logic [NUM_PERIPH_SRC-1:0] periph_int_flag,
	input wire logic wdt_timeout,
	input wire logic cpu_halt,
	input wire pme_pkg::pme_clk_s clk_ctl,
	input wire logic [1:0] periph_clk_sel,
	input wire pme_pkg::pme_flags_s osc_flags,
	input wire logic wake_to_vector,
	input wire logic wake_in_line
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	wire logic any_src = wdt_timeout || (|core_int_flag) || (|periph_int_flag);
	halt_entry_a: assert property (sleep_exec && !cpu_halt |=> cpu_halt)
		else $error("no halt after sleep instruction");
	cpu_off_a: assert property (cpu_halt |-> !clk_ctl.cpu_clk_en)
		else $error("cpu clock running while halted");
	idle_flags_a: assert property ($rose(cpu_halt) && clk_ctl.periph_clk_en |->
		osc_flags == $past(osc_flags)) else $error("flags changed on idle entry");
	idle_src_a: assert property (cpu_halt && $past(cpu_halt) && clk_ctl.periph_clk_en |->
		$stable(periph_clk_sel)) else $error("peripheral clock source moved in idle");
	sleep_osc_a: assert property (cpu_halt && !clk_ctl.periph_clk_en |->
		!clk_ctl.primary_osc_en && !clk_ctl.intosc_en) else $error("oscillator on in sleep");
	sleep_flags_a: assert property ($rose(cpu_halt) && !clk_ctl.periph_clk_en |->
		osc_flags == 3'b000) else $error("flags not cleared on sleep entry");
	wake_cause_a: assert property ($fell(cpu_halt) |-> $past(any_src))
		else $error("wake without a wake event");
	wdt_wake_a: assert property (cpu_halt && wdt_timeout |=> !cpu_halt)
		else $error("watchdog time-out did not wake");
	wake_pulse_a: assert property (wake_to_vector || wake_in_line |->
		$fell(cpu_halt) && !(wake_to_vector && wake_in_line)) else $error("bad wake pulse");
	cover property ($rose(cpu_halt) && clk_ctl.periph_clk_en);
	cover property ($rose(cpu_halt) && !clk_ctl.periph_clk_en);
	cover property (wake_to_vector);
	cover property (wake_in_line);
endmodule
bind pme_power_mode pme_power_mode_chk #(.NUM_CORE_SRC(NUM_CORE_SRC),
	.NUM_PERIPH_SRC(NUM_PERIPH_SRC)) chk_u (.mclk, .rst_n, .sleep_exec, .core_int_flag,
	.periph_int_flag, .wdt_timeout, .cpu_halt, .clk_ctl, .periph_clk_sel, .osc_flags,
	.wake_to_vector, .wake_in_line);

//--- bench/pme_power_mode_test.sv
// Purpose: self-checking bench of the power mode block
// Assumes: oscillator pins held high, save a short primary ready drop while in Idle
// Notes: every bus access waits for waitrequest low
`timescale 1ns/1ns
module pme_power_mode_test;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] avs_address = 8'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0000_0000;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic sleep_exec = 1'b0;
	logic [3:0] core_int_flag = 4'h0;
	logic [7:0] periph_int_flag = 8'h00;
	logic wdt_timeout = 1'b0;
	logic primary_osc_ready_pin = 1'b1;
	logic intosc_stable_pin = 1'b1;
	logic t1osc_running_pin = 1'b1;
	logic cpu_halt;
	pme_pkg::pme_clk_s clk_ctl;
	logic [1:0] periph_clk_sel;
	pme_pkg::pme_flags_s osc_flags;
	logic wake_to_vector;
	logic wake_in_line;
	logic irq;
	logic [31:0] rd;
	int n_errors = 0;
	int samples_checked = 0;

	always #4 mclk = ~mclk;

	pme_power_mode dut_u (.mclk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_readdata, .avs_waitrequest, .sleep_exec, .core_int_flag, .periph_int_flag,
		.wdt_timeout, .primary_osc_ready_pin, .intosc_stable_pin, .t1osc_running_pin,
		.cpu_halt, .clk_ctl, .periph_clk_sel, .osc_flags, .wake_to_vector, .wake_in_line,
		.irq);

	task automatic complete_run;
		if (n_errors == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
			n_errors++;
		end
	endtask

	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge mclk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		do begin
			@(posedge mclk);
			n++;
		end while (avs_waitrequest !== 1'b0);
		chk(32'(n), 32'h0000_0002);
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask

	task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0000_0000);
		chk(rd, exp);
	endtask

	task automatic sleep_now;
		@(posedge mclk);
		sleep_exec <= 1'b1;
		@(posedge mclk);
		sleep_exec <= 1'b0;
		#1;
	endtask

	task automatic wake(input logic [3:0] c, input logic [7:0] p, input logic w);
		@(posedge mclk);
		core_int_flag <= c;
		periph_int_flag <= p;
		wdt_timeout <= w;
		@(posedge mclk);
		core_int_flag <= 4'h0;
		periph_int_flag <= 8'h00;
		wdt_timeout <= 1'b0;
		#1;
	endtask

	task automatic t_regs;
		logic [7:0] offs [5];
		offs = '{pme_pkg::OFF_CTRL, pme_pkg::OFF_INTERRUPT_CONTROL_REGISTER, pme_pkg::OFF_PIE,
			pme_pkg::OFF_EVT, pme_pkg::OFF_MASK};
		foreach (offs[i])
			rchk(offs[i], 32'h0000_0000);
		rchk(pme_pkg::OFF_STAT, 32'h0000_0007);
		bus(1'b1, 8'h3C, 32'hFFFF_FFFF);
		rchk(8'h3C, 32'h0000_0000);
		bus(1'b1, pme_pkg::OFF_CTRL, 32'hFFFF_FFFF);
		rchk(pme_pkg::OFF_CTRL, 32'h0000_001F);
	endtask

	task automatic t_idle;
		bus(1'b1, pme_pkg::OFF_CTRL, 32'h0000_0005);
		bus(1'b1, pme_pkg::OFF_INTERRUPT_CONTROL_REGISTER, 32'h0000_0081);
		bus(1'b1, pme_pkg::OFF_MASK, 32'h0000_0004);
		sleep_now;
		chk({29'h0, cpu_halt, clk_ctl.cpu_clk_en, clk_ctl.periph_clk_en}, 32'h0000_0005);
		chk(32'(osc_flags), 32'h0000_0007);
		// pin drops in Idle; the frozen flag must not follow it
		@(posedge mclk);
		primary_osc_ready_pin <= 1'b0;
		bus(1'b1, pme_pkg::OFF_CTRL, 32'h0000_0003);
		chk(32'(periph_clk_sel), 32'h0000_0002);
		rchk(pme_pkg::OFF_STAT, 32'h0000_002F);
		@(posedge mclk);
		primary_osc_ready_pin <= 1'b1;
		wake(4'h1, 8'h00, 1'b0);
		chk({30'h0, wake_to_vector, cpu_halt}, 32'h0000_0002);
		rchk(pme_pkg::OFF_EVT, 32'h0000_0005);
		chk(32'(irq), 32'h0000_0001);
		bus(1'b1, pme_pkg::OFF_EVT, 32'h0000_0005);
		rchk(pme_pkg::OFF_EVT, 32'h0000_0000);
		chk(32'(irq), 32'h0000_0000);
	endtask

	task automatic t_sleep;
		bus(1'b1, pme_pkg::OFF_CTRL, 32'h0000_0018);
		bus(1'b1, pme_pkg::OFF_INTERRUPT_CONTROL_REGISTER, 32'h0000_0000);
		bus(1'b1, pme_pkg::OFF_PIE, 32'h0000_0002);
		sleep_now;
		chk(32'(clk_ctl), 32'h0000_0003);
		chk(32'(osc_flags), 32'h0000_0000);
		rchk(pme_pkg::OFF_STAT, 32'h0000_0030);
		wake(4'h1, 8'h01, 1'b0);
		chk(32'(cpu_halt), 32'h0000_0001);
		wake(4'h0, 8'h02, 1'b0);
		chk({29'h0, wake_to_vector, wake_in_line, cpu_halt}, 32'h0000_0002);
		rchk(pme_pkg::OFF_STAT, 32'h0000_0007);
	endtask

	task automatic t_wdt;
		bus(1'b1, pme_pkg::OFF_CTRL, 32'h0000_0000);
		sleep_now;
		chk(32'(clk_ctl), 32'h0000_0000);
		wake(4'h0, 8'h00, 1'b1);
		chk({29'h0, wake_to_vector, wake_in_line, cpu_halt}, 32'h0000_0002);
		rchk(pme_pkg::OFF_EVT, 32'h0000_000E);
	endtask

	initial begin
		#20000;
		n_errors++;
		complete_run;
	end

	initial begin
		repeat (12) @(posedge mclk);
		rst_n <= 1'b1;
		repeat (8) @(posedge mclk);
		t_regs;
		t_idle;
		t_sleep;
		t_wdt;
		complete_run;
	end
endmodule
